/* File: logic/tfs_pkg.sv */
`default_nettype none
package tfs_pkg;
  // File identifiers carried by a select command
  localparam logic [15:0] FID_SYS = 16'he101;
  localparam logic [15:0] FID_CC = 16'he103;
  localparam logic [15:0] FID_MSG = 16'h0001;
  // Capability container field offsets and fixed contents
  localparam logic [15:0] CC_OFF_LEN = 16'h0000;
  localparam logic [15:0] CC_OFF_VER = 16'h0002;
  localparam logic [15:0] CC_OFF_MAXRD = 16'h0003;
  localparam logic [15:0] CC_OFF_MAXWR = 16'h0005;
  localparam logic [15:0] CC_OFF_TLV = 16'h0007;
  localparam logic [15:0] CC_OFF_TLVLEN = 16'h0008;
  localparam logic [15:0] CC_OFF_FID = 16'h0009;
  localparam logic [15:0] CC_OFF_MAXSZ = 16'h000b;
  localparam logic [15:0] CC_OFF_RDPERM = 16'h000d;
  localparam logic [15:0] CC_OFF_WRPERM = 16'h000e;
  localparam logic [15:0] CC_LEN = 16'h000f;
  localparam logic [15:0] MAX_RW = 16'h00f6;
  localparam logic [15:0] MAX_MSG = 16'h0800;
  localparam logic [7:0] TLV_RST = 8'h04;
  localparam logic [7:0] TLV_LEN = 8'h06;
  localparam logic [7:0] VER_V2 = 8'h20;
  localparam logic [7:0] VER_V1 = 8'h10;
  // Access right encodings
  localparam logic [7:0] PERM_OPEN = 8'h00;
  localparam logic [7:0] PERM_LOCKED = 8'h80;
  localparam logic [7:0] RD_FORBID = 8'hfe;
  localparam logic [7:0] WR_FORBID = 8'hff;
  // System file offsets and delivery values
  localparam logic [15:0] SYS_OFF_LEN = 16'h0000;
  localparam logic [15:0] SYS_OFF_RSV0 = 16'h0002;
  localparam logic [15:0] SYS_OFF_RSV1 = 16'h0003;
  localparam logic [15:0] SYS_OFF_RSV2 = 16'h0004;
  localparam logic [15:0] SYS_OFF_RSV3 = 16'h0005;
  localparam logic [15:0] SYS_OFF_RSV4 = 16'h0006;
  localparam logic [15:0] SYS_OFF_NFILE = 16'h0007;
  localparam logic [15:0] SYS_OFF_UID = 16'h0008;
  localparam logic [15:0] SYS_OFF_MEM = 16'h000f;
  localparam logic [15:0] SYS_OFF_PART = 16'h0011;
  localparam logic [15:0] SYS_LEN = 16'h0012;
  localparam logic [15:0] MEM_SIZE = 16'h07ff;
  localparam logic [7:0] RSV0_VAL = 8'h01;
  localparam logic [7:0] RSV1_VAL = 8'h00;
  localparam logic [7:0] RSV2_VAL = 8'h11;
  localparam logic [7:0] RSV3_VAL = 8'h00;
  localparam logic [7:0] RSV4_VAL = 8'h01;
  localparam logic [7:0] NFILE_VAL = 8'h00;
  // Command codes, management fields and answer codes
  localparam logic [1:0] OP_SELECT = 2'h0;
  localparam logic [1:0] OP_READ = 2'h1;
  localparam logic [1:0] OP_UPDATE = 2'h2;
  localparam logic [1:0] OP_MGMT = 2'h3;
  localparam logic [1:0] MG_TLV = 2'h0;
  localparam logic [1:0] MG_RDPERM = 2'h1;
  localparam logic [1:0] MG_WRPERM = 2'h2;
  localparam logic [1:0] ST_OK = 2'h0;
  localparam logic [1:0] ST_ERR_RANGE = 2'h1;
  localparam logic [1:0] ST_ERR_ACCESS = 2'h2;
  localparam logic [1:0] ST_ERR_FILE = 2'h3;
  typedef enum logic [3:0] {
    SEL_NONE = 4'h1, SEL_CC = 4'h2, SEL_MSG = 4'h4, SEL_SYS = 4'h8
  } tfs_file_t;
  typedef enum logic [2:0] {
    FS_IDLE = 3'h1, FS_READ = 3'h2, FS_WRITE = 3'h4
  } tfs_state_t;
endpackage
`default_nettype wire

/* File: logic/tfs_store.sv */
`default_nettype none
module tfs_store #(
  parameter logic [7:0] MAP_VERSION = 8'h20,
  parameter logic [55:0] UNIQUE_ID = 56'h11_2233_4455_6677, // Arbitrary value
  parameter logic [7:0] PART_CODE = 8'h5a // Arbitrary value
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_cmd_valid,
  input wire logic [1:0] i_cmd_op,
  input wire logic [15:0] i_cmd_fid,
  input wire logic [15:0] i_cmd_offset,
  input wire logic [7:0] i_cmd_len,
  input wire logic [1:0] i_mgmt_field,
  input wire logic [7:0] i_mgmt_value,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr_valid,
  input wire logic i_rd_grant,
  input wire logic i_wr_grant,
  input wire logic i_session_end,
  output logic o_busy,
  output logic o_done,
  output logic [1:0] o_status,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  output logic o_wr_ready,
  output var tfs_pkg::tfs_file_t o_sel_file
);
  import tfs_pkg::*;
  localparam int MSG_AW = $clog2(MAX_MSG);
  if (MAP_VERSION != VER_V2 && MAP_VERSION != VER_V1) begin : g_bad_version
    $error("MAP_VERSION must be 0x20 or 0x10");
  end
  ////////////////////////////////////////////////////////////////////////////
  tfs_state_t state_r, state_nxt;
  tfs_file_t sel_r, fid_file;
  logic rd_grant_r, wr_grant_r;
  logic [7:0] rd_perm_r, wr_perm_r, tlv_r;
  logic [15:0] msg_len_r, cur_off_r;
  logic [7:0] cnt_r, rd_byte;
  logic [7:0] msg_mem [0:MAX_MSG-1];
  logic busy_r, done_r, rd_valid_r, wr_ready_r;
  logic [1:0] status_r;
  logic [7:0] rd_data_r;
  logic accept, go_rd, go_wr, done_now, mgmt_ok, rd_acc_ok, wr_acc_ok;
  logic [1:0] cmd_status;
  logic [16:0] req_end, rd_limit;
  logic wr_fire, last_step;
  // Every output straight from a flop
  assign o_busy = busy_r;
  assign o_done = done_r;
  assign o_status = status_r;
  assign o_rd_data = rd_data_r;
  assign o_rd_valid = rd_valid_r;
  assign o_wr_ready = wr_ready_r;
  assign o_sel_file = sel_r;
  ////////////////////////////////////////////////////////////////////////////
  // Identifier decode; anything else is not a file of this tag
  // three files only
  always_comb begin
    fid_file = SEL_NONE;
    if (i_cmd_fid == FID_CC) fid_file = SEL_CC;
    else if (i_cmd_fid == FID_MSG) fid_file = SEL_MSG;
    else if (i_cmd_fid == FID_SYS) fid_file = SEL_SYS;
  end
  // Read boundary per file; message bound follows the stored length
  // length bounds
  always_comb begin
    rd_limit = 17'h0;
    unique case (sel_r)
      SEL_CC: rd_limit = {1'b0, CC_LEN};
      SEL_SYS: rd_limit = {1'b0, SYS_LEN};
      SEL_MSG: rd_limit = {1'b0, msg_len_r} + 17'h2;
      SEL_NONE: rd_limit = 17'h0;
    endcase
  end
  // Locked rights need a grant from the password checker
  // rights encodings
  assign rd_acc_ok = (sel_r != SEL_MSG) || (rd_perm_r == PERM_OPEN) ||
                     (rd_perm_r == PERM_LOCKED && rd_grant_r);
  assign wr_acc_ok = (wr_perm_r == PERM_OPEN) || (wr_perm_r == PERM_LOCKED && wr_grant_r);
  assign req_end = {1'b0, i_cmd_offset} + {9'h0, i_cmd_len};
  assign accept = (state_r == FS_IDLE) && i_cmd_valid && !i_session_end;
  // Management may never move a right out of its forbidden state
  // management path
  always_comb begin
    mgmt_ok = 1'b0;
    unique case (i_mgmt_field)
      MG_TLV: mgmt_ok = 1'b1;
      MG_RDPERM: mgmt_ok = (rd_perm_r != RD_FORBID) && (i_mgmt_value == PERM_OPEN ||
                 i_mgmt_value == PERM_LOCKED || i_mgmt_value == RD_FORBID);
      MG_WRPERM: mgmt_ok = (wr_perm_r != WR_FORBID) && (i_mgmt_value == PERM_OPEN ||
                 i_mgmt_value == PERM_LOCKED || i_mgmt_value == WR_FORBID);
      default: mgmt_ok = 1'b0;
    endcase
  end
  // Command check; ranges longer than one command allows are refused
  // command-only access
  always_comb begin
    cmd_status = ST_OK;
    go_rd = 1'b0;
    go_wr = 1'b0;
    unique case (i_cmd_op)
      OP_SELECT: cmd_status = (fid_file == SEL_NONE) ? ST_ERR_FILE : ST_OK;
      OP_READ: begin
        if (sel_r == SEL_NONE) cmd_status = ST_ERR_FILE;
        else if (!rd_acc_ok) cmd_status = ST_ERR_ACCESS;
        else if ({8'h0, i_cmd_len} > MAX_RW || req_end > rd_limit) cmd_status = ST_ERR_RANGE;
        else go_rd = (i_cmd_len != 8'h00);
      end
      OP_UPDATE: begin
        // only the message file takes updates
        if (sel_r == SEL_NONE) cmd_status = ST_ERR_FILE;
        else if (sel_r != SEL_MSG || !wr_acc_ok) cmd_status = ST_ERR_ACCESS;
        else if ({8'h0, i_cmd_len} > MAX_RW || req_end > {1'b0, MAX_MSG})
          cmd_status = ST_ERR_RANGE;
        else go_wr = (i_cmd_len != 8'h00);
      end
      OP_MGMT: cmd_status = mgmt_ok ? ST_OK : ST_ERR_ACCESS;
    endcase
  end
  // Progress strobes of the running command
  assign done_now = accept && !go_rd && !go_wr;
  assign wr_fire = (state_r == FS_WRITE) && i_wr_valid && wr_ready_r;
  assign last_step = (cnt_r == 8'h01) && ((state_r == FS_READ) || wr_fire);
  // Next state; session end wins over everything
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      FS_IDLE: begin
        if (accept && go_rd) state_nxt = FS_READ;
        else if (accept && go_wr) state_nxt = FS_WRITE;
      end
      FS_READ, FS_WRITE: if (last_step) state_nxt = FS_IDLE;
    endcase
    if (i_session_end) state_nxt = FS_IDLE;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Transfer sequencer; session end aborts any transfer in flight
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      state_r <= FS_IDLE;
      busy_r <= 1'b0;
      wr_ready_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      busy_r <= (state_nxt != FS_IDLE);
      wr_ready_r <= (state_nxt == FS_WRITE);
    end
  end
  // Offset and remaining byte count of the running transfer
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      cur_off_r <= 16'h0000;
      cnt_r <= 8'h00;
    end else if (accept) begin
      cur_off_r <= i_cmd_offset;
      cnt_r <= i_cmd_len;
    end else if (state_r == FS_READ || wr_fire) begin
      cur_off_r <= cur_off_r + 16'h1;
      cnt_r <= cnt_r - 8'h1;
    end
  end
  // Selected file and granted rights; a grant pulse wins over a revoke
  // revoke on session end or reselect
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      sel_r <= SEL_NONE;
      rd_grant_r <= 1'b0;
      wr_grant_r <= 1'b0;
    end else begin
      if (i_session_end) sel_r <= SEL_NONE;
      else if (accept && i_cmd_op == OP_SELECT) sel_r <= fid_file;
      if (i_session_end || (accept && i_cmd_op == OP_SELECT && fid_file != sel_r)) begin
        rd_grant_r <= i_rd_grant;
        wr_grant_r <= i_wr_grant;
      end else begin
        rd_grant_r <= rd_grant_r | i_rd_grant;
        wr_grant_r <= wr_grant_r | i_wr_grant;
      end
    end
  end
  // Container fields that management may rewrite
  // open on delivery; management only
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      tlv_r <= TLV_RST;
      rd_perm_r <= PERM_OPEN;
      wr_perm_r <= PERM_OPEN;
    end else if (accept && i_cmd_op == OP_MGMT && mgmt_ok) begin
      if (i_mgmt_field == MG_TLV) tlv_r <= i_mgmt_value;
      if (i_mgmt_field == MG_RDPERM) rd_perm_r <= i_mgmt_value;
      if (i_mgmt_field == MG_WRPERM) wr_perm_r <= i_mgmt_value;
    end
  end
  // Message store; no reset since it models non-volatile cells
  always_ff @(posedge i_ref_clk) begin
    if (wr_fire) msg_mem[cur_off_r[MSG_AW-1:0]] <= i_wr_data;
  end
  // Length shadow keeps the read bound defined from reset
  // length taken as written
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) msg_len_r <= 16'h0000;
    else if (wr_fire && cur_off_r == 16'h0000) msg_len_r[15:8] <= i_wr_data;
    else if (wr_fire && cur_off_r == 16'h0001) msg_len_r[7:0] <= i_wr_data;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Byte served at the current offset, big-endian fields
  // file images
  always_comb begin
    rd_byte = 8'h00;
    unique case (sel_r)
      SEL_CC: begin
        case (cur_off_r)
          CC_OFF_LEN: rd_byte = CC_LEN[15:8];
          CC_OFF_LEN + 16'h1: rd_byte = CC_LEN[7:0];
          CC_OFF_VER: rd_byte = MAP_VERSION;
          CC_OFF_MAXRD: rd_byte = MAX_RW[15:8];
          CC_OFF_MAXRD + 16'h1: rd_byte = MAX_RW[7:0];
          CC_OFF_MAXWR: rd_byte = MAX_RW[15:8];
          CC_OFF_MAXWR + 16'h1: rd_byte = MAX_RW[7:0];
          CC_OFF_TLV: rd_byte = tlv_r;
          CC_OFF_TLVLEN: rd_byte = TLV_LEN;
          CC_OFF_FID: rd_byte = FID_MSG[15:8];
          CC_OFF_FID + 16'h1: rd_byte = FID_MSG[7:0];
          CC_OFF_MAXSZ: rd_byte = MAX_MSG[15:8];
          CC_OFF_MAXSZ + 16'h1: rd_byte = MAX_MSG[7:0];
          CC_OFF_RDPERM: rd_byte = rd_perm_r;
          CC_OFF_WRPERM: rd_byte = wr_perm_r;
          default: rd_byte = 8'h00;
        endcase
      end
      SEL_SYS: begin
        case (cur_off_r)
          SYS_OFF_LEN: rd_byte = SYS_LEN[15:8];
          SYS_OFF_LEN + 16'h1: rd_byte = SYS_LEN[7:0];
          SYS_OFF_RSV0: rd_byte = RSV0_VAL;
          SYS_OFF_RSV1: rd_byte = RSV1_VAL;
          SYS_OFF_RSV2: rd_byte = RSV2_VAL;
          SYS_OFF_RSV3: rd_byte = RSV3_VAL;
          SYS_OFF_RSV4: rd_byte = RSV4_VAL;
          SYS_OFF_NFILE: rd_byte = NFILE_VAL;
          SYS_OFF_MEM: rd_byte = MEM_SIZE[15:8];
          SYS_OFF_MEM + 16'h1: rd_byte = MEM_SIZE[7:0];
          SYS_OFF_PART: rd_byte = PART_CODE;
          default: begin
            // Seven identifier bytes, most significant first
            if (cur_off_r >= SYS_OFF_UID && cur_off_r < SYS_OFF_MEM)
              rd_byte = UNIQUE_ID[8 * (int'(SYS_OFF_MEM) - 1 - int'(cur_off_r)) +: 8];
          end
        endcase
      end
      SEL_MSG: begin
        if (cur_off_r == 16'h0000) rd_byte = msg_len_r[15:8];
        else if (cur_off_r == 16'h0001) rd_byte = msg_len_r[7:0];
        else rd_byte = msg_mem[cur_off_r[MSG_AW-1:0]];
      end
      SEL_NONE: rd_byte = 8'h00;
    endcase
  end
  // Answer flops: one byte per cycle, done with the last byte
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      done_r <= 1'b0;
      status_r <= ST_OK;
      rd_valid_r <= 1'b0;
      rd_data_r <= 8'h00;
    end else begin
      done_r <= done_now || (last_step && !i_session_end);
      if (done_now) status_r <= cmd_status;
      else if (last_step) status_r <= ST_OK;
      rd_valid_r <= (state_r == FS_READ) && !i_session_end;
      if (state_r == FS_READ) rd_data_r <= rd_byte;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_upd_req;
    accept && i_cmd_op == OP_UPDATE;
  endsequence
  sequence s_err_done(logic [1:0] code);
    done_r && status_r == code;
  endsequence
  a_cc_readonly: assert property (
    s_upd_req and (sel_r == SEL_CC) |=> s_err_done(ST_ERR_ACCESS) and !wr_ready_r)
    else $error("update on container not refused");
  a_sys_noupdate: assert property (
    s_upd_req and (sel_r == SEL_SYS) |=> s_err_done(ST_ERR_ACCESS))
    else $error("update on system file not refused");
  a_tlv_stable: assert property (
    !(accept && i_cmd_op == OP_MGMT) |=> $stable(tlv_r) && $stable(rd_perm_r) &&
    $stable(wr_perm_r))
    else $error("container field changed outside management");
  a_cc_len_byte: assert property (
    state_r == FS_READ && sel_r == SEL_CC && cur_off_r == 16'h0001 |=> rd_data_r == 8'h0f)
    else $error("container length byte wrong");
  a_maxrd_byte: assert property (
    state_r == FS_READ && sel_r == SEL_CC && cur_off_r == 16'h0004 |=> rd_data_r == 8'hf6)
    else $error("read limit byte wrong");
  a_msg_bound: assert property (
    accept && i_cmd_op == OP_READ && sel_r == SEL_MSG && rd_acc_ok &&
    req_end > {1'b0, msg_len_r} + 17'h2 |=> s_err_done(ST_ERR_RANGE) ##1 !rd_valid_r)
    else $error("read beyond message length served");
  a_forbid_final: assert property (
    rd_perm_r == RD_FORBID |=> rd_perm_r == RD_FORBID)
    else $error("read right left forbidden state");
  a_grant_revoke: assert property (
    i_session_end && !i_rd_grant && !i_wr_grant |=> !rd_grant_r && !wr_grant_r
    && sel_r == SEL_NONE)
    else $error("rights survived session end");
  a_sel_fid: assert property (
    accept && i_cmd_op == OP_SELECT && i_cmd_fid == FID_MSG |=> sel_r == SEL_MSG and
    s_err_done(ST_OK))
    else $error("message select failed");
  a_sys_bound: assert property (
    accept && i_cmd_op == OP_READ && sel_r == SEL_SYS && req_end > 17'h12
    |=> s_err_done(ST_ERR_RANGE))
    else $error("system read beyond length served");
endmodule
`default_nettype wire

/* File: sim/tfs_host.sv */
`default_nettype none
module tfs_host (
  input wire logic i_ref_clk,
  input wire logic i_done,
  input wire logic [1:0] i_status,
  input wire logic [7:0] i_rd_data,
  input wire logic i_rd_valid,
  input wire logic i_wr_ready,
  output logic o_cmd_valid,
  output logic [1:0] o_cmd_op,
  output logic [15:0] o_cmd_fid,
  output logic [15:0] o_cmd_offset,
  output logic [7:0] o_cmd_len,
  output logic [1:0] o_mgmt_field,
  output logic [7:0] o_mgmt_value,
  output logic [7:0] o_wr_data,
  output logic o_wr_valid,
  output logic o_rd_grant,
  output logic o_wr_grant,
  output logic o_session_end
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] wq[$];
  logic [7:0] rq[$];
  logic [1:0] st;
  bit hung;
  bit slow;
  bit sent;

  // Idle levels at time zero
  initial begin
    {o_cmd_valid, o_cmd_op, o_cmd_fid, o_cmd_offset, o_cmd_len} = '0;
    {o_mgmt_field, o_mgmt_value, o_wr_data, o_wr_valid} = '0;
    {o_rd_grant, o_wr_grant, o_session_end} = '0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // One command, held for one edge, then bytes streamed until completion
  // Select by identifier
  task automatic cmd(input logic [1:0] op, input logic [15:0] fid, input logic [15:0] off,
                     input logic [7:0] len, input logic [1:0] fld, input logic [7:0] val);
    int n;
    rq = {};
    hung = 1'b1;
    sent = 1'b0;
    @(negedge i_ref_clk);
    {o_cmd_op, o_cmd_fid, o_cmd_offset, o_cmd_len} = {op, fid, off, len};
    {o_mgmt_field, o_mgmt_value, o_cmd_valid} = {fld, val, 1'b1};
    for (n = 0; n < 600 && hung; n++) begin
      @(negedge i_ref_clk);
      o_cmd_valid = 1'b0;
      if (sent) void'(wq.pop_front());
      if (i_rd_valid) rq.push_back(i_rd_data);
      if (i_done) begin
        st = i_status;
        hung = 1'b0;
      end
      // Slow mode stalls at random; a released data line toggles every cycle
      sent = !i_done && i_wr_ready && wq.size() > 0 && !(slow && $urandom_range(1, 0) == 0);
      o_wr_valid = sent;
      o_wr_data = sent ? wq[0] : ~o_wr_data;
    end
    wq = {};
  endtask

  // One-cycle pulse: 2 read grant, 1 write grant, 0 session end
  task automatic pulse(input int which);
    @(negedge i_ref_clk);
    {o_rd_grant, o_wr_grant, o_session_end} = 3'(1 << which);
    @(negedge i_ref_clk);
    {o_rd_grant, o_wr_grant, o_session_end} = 3'h0;
  endtask
endmodule
`default_nettype wire

/* File: sim/tag_file_store_map_test.sv */
`default_nettype none
module tag_file_store_map_test;
  timeunit 1ns;
  timeprecision 1ps;
  import tfs_pkg::*;
  localparam logic [55:0] UNIQUE_IDENTIFIER = 56'h3c_4d5e_6f70_8192; // Arbitrary value
  localparam logic [7:0] PART = 8'h6b; // Arbitrary value
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid, wr_valid, rd_grant, wr_grant, session_end, busy, done, rd_valid, wr_ready;
  logic [1:0] cmd_op, mgmt_field, status;
  logic [15:0] cmd_fid, cmd_offset;
  logic [7:0] cmd_len, mgmt_value, wr_data, rd_data;
  tfs_file_t sel_file;
  int mem[2048];
  int slen, rdp, wrp, tlv, rgr, wgr, miscompares, num_checks;
  tfs_file_t sel;
  logic [15:0] fids[4] = '{FID_CC, FID_SYS, 16'he102, FID_MSG};
  logic [9:0] mg[7] = '{{MG_RDPERM, 8'h55}, {2'h3, 8'h00}, {MG_RDPERM, 8'hfe},
    {MG_RDPERM, 8'h00}, {MG_WRPERM, 8'hff}, {MG_WRPERM, 8'h80}, {MG_TLV, 8'h05}};

  tfs_store #(.MAP_VERSION(VER_V1), .UNIQUE_ID(UNIQUE_IDENTIFIER), .PART_CODE(PART)) i_dut (
    .i_ref_clk(clk), .i_sys_rst(rst), .i_cmd_valid(cmd_valid), .i_cmd_op(cmd_op),
    .i_cmd_fid(cmd_fid), .i_cmd_offset(cmd_offset), .i_cmd_len(cmd_len),
    .i_mgmt_field(mgmt_field), .i_mgmt_value(mgmt_value), .i_wr_data(wr_data),
    .i_wr_valid(wr_valid), .i_rd_grant(rd_grant), .i_wr_grant(wr_grant),
    .i_session_end(session_end), .o_busy(busy), .o_done(done), .o_status(status),
    .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_wr_ready(wr_ready), .o_sel_file(sel_file));

  tfs_host i_host (
    .i_ref_clk(clk), .i_done(done), .i_status(status), .i_rd_data(rd_data),
    .i_rd_valid(rd_valid), .i_wr_ready(wr_ready), .o_cmd_valid(cmd_valid),
    .o_cmd_op(cmd_op), .o_cmd_fid(cmd_fid), .o_cmd_offset(cmd_offset), .o_cmd_len(cmd_len),
    .o_mgmt_field(mgmt_field), .o_mgmt_value(mgmt_value), .o_wr_data(wr_data),
    .o_wr_valid(wr_valid), .o_rd_grant(rd_grant), .o_wr_grant(wr_grant),
    .o_session_end(session_end));

  // Free-running clock, 4 ns period
  always #2 clk = ~clk;

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    if (miscompares == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Expected byte of the selected file; -1 where the message byte is unknown
  function automatic int img(int a);
    logic [7:0] c[15] = '{8'h00, 8'h0f, 8'h10, 8'h00, 8'hf6, 8'h00, 8'hf6, 8'h04, 8'h06,
      8'h00, 8'h01, 8'h08, 8'h00, 8'h00, 8'h00};
    logic [7:0] s[18] = '{8'h00, 8'h12, 8'h01, 8'h00, 8'h11, 8'h00, 8'h01, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h07, 8'hff, PART};
    c[7] = tlv[7:0];
    c[13] = rdp[7:0];
    c[14] = wrp[7:0];
    for (int i = 0; i < 7; i++) s[8 + i] = UNIQUE_IDENTIFIER[55 - 8 * i -: 8];
    return sel == SEL_CC ? int'(c[a]) : sel == SEL_SYS ? int'(s[a]) : mem[a];
  endfunction

  // Model one command, run it through the host, compare status, bytes, selection
  task automatic run(input logic [1:0] op, input logic [15:0] a, input int len,
                     input logic [1:0] fld = 2'h0, input logic [7:0] val = 8'h00);
    logic [1:0] e;
    logic [7:0] q[$];
    int lim;
    tfs_file_t was;
    q = i_host.wq;
    e = ST_OK;
    lim = sel == SEL_CC ? 15 : sel == SEL_SYS ? 18 : op == OP_READ ? slen + 2 : 2048;
    case (op)
      OP_SELECT: begin
        was = sel;
        sel = a == FID_CC ? SEL_CC : a == FID_SYS ? SEL_SYS : a == FID_MSG ? SEL_MSG : SEL_NONE;
        e = sel == SEL_NONE ? ST_ERR_FILE : ST_OK;
        // Rights fall only when another file is picked
        if (sel != was) {rgr, wgr} = '0;
      end
      OP_MGMT: begin
        if (fld == MG_TLV) tlv = val;
        else if (fld == MG_RDPERM && rdp != 'hfe && val inside {8'h00, 8'h80, 8'hfe}) rdp = val;
        else if (fld == MG_WRPERM && wrp != 'hff && val inside {8'h00, 8'h80, 8'hff}) wrp = val;
        else e = ST_ERR_ACCESS;
      end
      default: begin
        if (sel == SEL_NONE) e = ST_ERR_FILE;
        else if (len == 0) e = ST_OK;
        else if (op == OP_UPDATE ? sel != SEL_MSG || wrp == 'hff || (wrp == 'h80 && wgr == 0)
            : sel == SEL_MSG && (rdp == 'hfe || (rdp == 'h80 && rgr == 0))) e = ST_ERR_ACCESS;
        else if (len > 246 || a + len > lim) e = ST_ERR_RANGE;
      end
    endcase
    if (e == ST_OK && op == OP_UPDATE) begin
      foreach (q[i]) mem[a + i] = q[i];
      if (a < 2) slen = mem[0] * 256 + mem[1];
    end
    i_host.cmd(op, a, a, 8'(len), fld, val);
    if (i_host.hung) begin
      miscompares++;
      report_and_stop();
    end else begin
      chk(16'(i_host.st), 16'(e));
      chk(16'(sel_file), 16'(sel));
      chk(16'({busy, wr_ready}), 16'h0000);
      if (op == OP_READ && e == ST_OK) begin
        chk(16'(i_host.rq.size()), 16'(len));
        for (int i = 0; i < len; i++)
          if (img(a + i) >= 0) chk(16'(i_host.rq[i]), 16'(img(a + i)));
      end
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(72));
    foreach (mem[i]) mem[i] = -1;
    {slen, rdp, wrp, rgr, wgr, miscompares, num_checks} = '0;
    tlv = 4;
    sel = SEL_NONE;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    chk(16'(sel_file), 16'(SEL_NONE));
    foreach (fids[i]) begin
      run(OP_SELECT, fids[i], 0);
      i_host.wq = '{8'h5a};
      run(OP_UPDATE, 2, 1);
      run(OP_READ, 0, sel == SEL_CC ? 15 : 18);
      run(OP_READ, 1, sel == SEL_CC ? 15 : 18);
    end
    i_host.wq = '{8'h00, 8'hc6};
    repeat (198) i_host.wq.push_back(8'($urandom));
    i_host.slow = 1'b1;
    run(OP_UPDATE, 0, 200);
    run(OP_READ, 0, 200);
    run(OP_READ, 100, 101);
    i_host.wq = '{8'h07, 8'hff};
    run(OP_UPDATE, 0, 2);
    run(OP_READ, 150, 246);
    run(OP_READ, 0, 247);
    run(OP_UPDATE, 2040, 9);
    repeat (246) i_host.wq.push_back(8'($urandom));
    run(OP_UPDATE, 1802, 246);
    // Grants revoked by reselect and session end
    run(OP_MGMT, 0, 0, MG_RDPERM, 8'h80);
    run(OP_READ, 0, 4);
    i_host.pulse(2);
    rgr = 1;
    run(OP_SELECT, FID_MSG, 0);
    run(OP_READ, 1802, 4);
    run(OP_SELECT, FID_CC, 0);
    run(OP_SELECT, FID_MSG, 0);
    run(OP_READ, 0, 4);
    run(OP_MGMT, 0, 0, MG_WRPERM, 8'h80);
    i_host.wq = '{8'h07, 8'hfe};
    run(OP_UPDATE, 0, 2);
    i_host.pulse(1);
    wgr = 1;
    i_host.wq = '{8'h07, 8'hfe};
    run(OP_UPDATE, 0, 2);
    i_host.pulse(0);
    sel = SEL_NONE;
    {rgr, wgr} = '0;
    chk(16'(sel_file), 16'(SEL_NONE));
    run(OP_SELECT, FID_MSG, 0);
    foreach (mg[i]) run(OP_MGMT, 0, 0, mg[i][9:8], mg[i][7:0]);
    i_host.pulse(2);
    run(OP_READ, 0, 2);
    run(OP_SELECT, FID_CC, 0);
    run(OP_READ, 0, 15);
    // Session end in mid-read: no completion, selection dropped
    fork
      i_host.cmd(OP_READ, 16'h0000, 16'h0000, 8'h0f, 2'h0, 8'h00);
      begin
        repeat (4) @(negedge clk);
        chk(16'(busy), 16'h0001);
        i_host.pulse(0);
        chk(16'(busy), 16'h0000);
      end
    join
    chk(16'(i_host.hung), 16'h0001);
    chk(16'(sel_file), 16'(SEL_NONE));
    report_and_stop();
  end
endmodule
`default_nettype wire
